/* core/scaler_wd_defines.vh */
`ifndef SCALER_WD_DEFINES_VH
`define SCALER_WD_DEFINES_VH
`define OFF_CTRL 8'h00
`define OFF_GAIN 8'h04
`define OFF_OFFSET 8'h08
`define OFF_UPPER 8'h0c
`define OFF_LOWER 8'h10
`define OFF_STATUS 8'h14
`define OFF_IRQ_STAT 8'h18
`define OFF_IRQ_MASK 8'h1c
`define OFF_REF 8'h20
`define OFF_LIVE 8'h24
`define OFF_OUT 8'h28
`define CTRL_AMP_MODE 0
`define CTRL_RETAIN 1
`define CTRL_UP_SRC 2
`define CTRL_LO_SRC 3
`define CTRL_DEC_LSB 4
`define CTRL_DEC_MSB 5
`define CTRL_SEL_UP_LSB 8
`define CTRL_SEL_UP_MSB 15
`define CTRL_SEL_LO_LSB 16
`define CTRL_SEL_LO_MSB 23
`define GAIN_MAX 16'sd1000
`define GAIN_MIN -16'sd1000
`define OFFSET_MAX 16'sd10000
`define OFFSET_MIN -16'sd10000
`define MARGIN_MAX 17'd20000
`define OUT_MAX 32'sd32767
`define OUT_MIN -32'sd32767
`define GAIN_DIV 32'sd100
`define IRQ_TRIP_SET 0
`define IRQ_TRIP_CLR 1
`define IRQ_ARM 2
`define SLVERR 2'b10
`define OKAY 2'b00
`endif

/* core/scale_stage.v */
`timescale 1ns/100ps
`include "scaler_wd_defines.vh"
// Gain is hundredths; value = in*gain/100 + offset, truncated toward zero.
module scale_stage (
	input wire signed [15:0] value_i,
	input wire signed [15:0] gain_i,
	input wire signed [15:0] offset_i,
	output wire signed [31:0] result_o
);
	wire signed [31:0] prod;
	assign prod = value_i * gain_i;
	assign result_o = prod / `GAIN_DIV + offset_i;
endmodule

/* core/sat_limit.v */
`timescale 1ns/100ps
`include "scaler_wd_defines.vh"
module sat_limit (
	input wire signed [31:0] value_i,
	output wire signed [15:0] value_o
);
	// Clamp rather than wrap so a large gain never flips the sign
	assign value_o = (value_i > `OUT_MAX) ? 16'sh7fff :
		(value_i < `OUT_MIN) ? 16'sh8001 : value_i[15:0];
endmodule

/* core/analog_scaler_watchdog.v */
`timescale 1ns/100ps
`include "scaler_wd_defines.vh"
// How it works
// - Enable rising edge captures scaled input as the reference.
// - Input and reference are scaled: times gain, plus offset.
// - With enable high outside amplifier mode, trip when input leaves reference minus lower to plus upper.
// - Trip clears when input is inside the window or enable is low.
// - Each margin can come from a selected block's actual value.
// - Decimal places setting is stored for display only, no effect on logic.
// - Gain is hundredths, limited to -10.00..10.00.
// - Offset is limited to -10000..10000.
// - Amplifier mode drives the scaled input onto the analog output.
// - Amplifier output stays within -32767..32767.
// - Margins are limited to 0..20000.
// - Retentive option keeps trip status over power loss; else cleared.
module analog_scaler_watchdog (
	input wire CLK_SYS_I,
	input wire RESET_N_I,
	input wire POWER_LOSS_I,
	input wire ENABLE_I,
	input wire signed [15:0] ANALOG_IN_I,
	input wire [2047:0] BLOCK_VALUES_I,
	output reg TRIP_O,
	output reg signed [15:0] SCALED_OUT_O,
	output wire IRQ_O,
	input wire [31:0] S_AXI_AWADDR_I,
	input wire S_AXI_AWVALID_I,
	output wire S_AXI_AWREADY_O,
	input wire [31:0] S_AXI_WDATA_I,
	input wire [3:0] S_AXI_WSTRB_I,
	input wire S_AXI_WVALID_I,
	output wire S_AXI_WREADY_O,
	output reg [1:0] S_AXI_BRESP_O,
	output reg S_AXI_BVALID_O,
	input wire S_AXI_BREADY_I,
	input wire [31:0] S_AXI_ARADDR_I,
	input wire S_AXI_ARVALID_I,
	output wire S_AXI_ARREADY_O,
	output reg [31:0] S_AXI_RDATA_O,
	output reg [1:0] S_AXI_RRESP_O,
	output reg S_AXI_RVALID_O,
	input wire S_AXI_RREADY_I
);
	reg [31:0] ctrl_reg;
	reg signed [15:0] gain_reg;
	reg signed [15:0] offset_reg;
	reg [15:0] upper_margin_reg;
	reg [15:0] lower_margin_reg;
	reg [2:0] irq_stat_reg;
	reg [2:0] irq_mask_reg;
	reg enable_last_reg;
	reg signed [31:0] reference_reg;
	reg retained_trip_reg;
	reg aw_held_reg;
	reg w_held_reg;
	reg [31:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg trip_next;
	wire signed [31:0] scaled_live;
	wire signed [15:0] sat_live;
	wire enable_rise;
	wire [7:0] sel_up;
	wire [7:0] sel_lo;
	wire signed [15:0] ext_up;
	wire signed [15:0] ext_lo;
	reg [16:0] upper_margin;
	reg [16:0] lower_margin;
	wire signed [33:0] win_hi;
	wire signed [33:0] win_lo;
	wire [1:0] decimals;
	wire wr_fire;
	wire [7:0] wa;
	wire [31:0] wd;
	wire signed [15:0] wd16;
	wire [2:0] irq_events;
	reg [31:0] rd_mux;
	reg rd_ok;
	reg wr_ok;

	wire signed [33:0] live_ext;
	wire signed [33:0] ref_ext;
	wire above_win;
	wire below_win;
	wire trip_allowed;
	wire wr_accept;
	wire [31:0] status_word;

	scale_stage u_scale (
		.value_i(ANALOG_IN_I),
		.gain_i(gain_reg),
		.offset_i(offset_reg),
		.result_o(scaled_live)
	);

	sat_limit u_sat (
		.value_i(scaled_live),
		.value_o(sat_live)
	);

	assign enable_rise = ENABLE_I & ~enable_last_reg;
	assign sel_up = ctrl_reg[`CTRL_SEL_UP_MSB:`CTRL_SEL_UP_LSB];
	assign sel_lo = ctrl_reg[`CTRL_SEL_LO_MSB:`CTRL_SEL_LO_LSB];
	assign ext_up = BLOCK_VALUES_I[sel_up*16 +: 16];
	assign ext_lo = BLOCK_VALUES_I[sel_lo*16 +: 16];
	// Held for display logic elsewhere; no arithmetic reads it
	assign decimals = ctrl_reg[`CTRL_DEC_MSB:`CTRL_DEC_LSB];

	// Block-sourced margins clamp to the legal margin range
	always @* begin
		if (ctrl_reg[`CTRL_UP_SRC]) begin
			if (ext_up[15])
				upper_margin = 17'd0;
			else if ({1'b0, ext_up} > `MARGIN_MAX)
				upper_margin = `MARGIN_MAX;
			else
				upper_margin = {1'b0, ext_up};
		end else begin
			upper_margin = {1'b0, upper_margin_reg};
		end
		if (ctrl_reg[`CTRL_LO_SRC]) begin
			if (ext_lo[15])
				lower_margin = 17'd0;
			else if ({1'b0, ext_lo} > `MARGIN_MAX)
				lower_margin = `MARGIN_MAX;
			else
				lower_margin = {1'b0, ext_lo};
		end else begin
			lower_margin = {1'b0, lower_margin_reg};
		end
	end

	// Two guard bits keep reference plus margin from wrapping near the 32-bit limits
	assign ref_ext = $signed({{2{reference_reg[31]}}, reference_reg});
	assign live_ext = $signed({{2{scaled_live[31]}}, scaled_live});
	assign win_hi = ref_ext + $signed({17'd0, upper_margin});
	assign win_lo = ref_ext - $signed({17'd0, lower_margin});
	// Signed compare throughout: a negative live value must never look huge
	assign above_win = live_ext > win_hi;
	assign below_win = live_ext < win_lo;
	// No decision in the capture cycle: the reference is not yet in place
	assign trip_allowed = ENABLE_I & ~enable_rise;

	always @* begin
		trip_next = 1'b0;
		if (trip_allowed)
			trip_next = above_win || below_win;
	end

	always @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			enable_last_reg <= 1'b0;
			reference_reg <= 32'sd0;
			TRIP_O <= 1'b0;
			SCALED_OUT_O <= 16'sh0000;
			retained_trip_reg <= 1'b0;
		end else begin
			enable_last_reg <= ENABLE_I;
			if (enable_rise)
				reference_reg <= scaled_live;
			if (POWER_LOSS_I) begin
				// A loss lasting many cycles must not overwrite the saved status with the forced zero
				if (ctrl_reg[`CTRL_RETAIN])
					retained_trip_reg <= retained_trip_reg | TRIP_O;
				else
					retained_trip_reg <= 1'b0;
				TRIP_O <= 1'b0;
			end else if (ctrl_reg[`CTRL_AMP_MODE]) begin
				TRIP_O <= 1'b0;
			end else if (retained_trip_reg && trip_allowed) begin
				TRIP_O <= 1'b1;
				retained_trip_reg <= 1'b0;
			end else begin
				retained_trip_reg <= 1'b0;
				TRIP_O <= trip_next;
			end
			if (ctrl_reg[`CTRL_AMP_MODE])
				SCALED_OUT_O <= sat_live;
		end
	end

	// AXI4-Lite slave: address and data latched independently
	assign S_AXI_AWREADY_O = ~aw_held_reg & ~S_AXI_BVALID_O;
	assign S_AXI_WREADY_O = ~w_held_reg & ~S_AXI_BVALID_O;
	assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;
	assign wr_fire = aw_held_reg & w_held_reg & ~S_AXI_BVALID_O;
	// Only the low address byte decodes; higher address bits alias the map
	assign wa = awaddr_reg[7:0];
	assign wd = wdata_reg;
	assign wd16 = wdata_reg[15:0];
	assign wr_accept = wr_fire & wr_ok & (wstrb_reg == 4'hf);
	// Bit 3 only hints the display format; no decision reads it
	assign status_word = {28'h0, decimals == 2'b00, retained_trip_reg, ENABLE_I, TRIP_O};

	assign irq_events[`IRQ_TRIP_SET] = trip_next & ~TRIP_O & ~ctrl_reg[`CTRL_AMP_MODE];
	assign irq_events[`IRQ_TRIP_CLR] = ~trip_next & TRIP_O;
	assign irq_events[`IRQ_ARM] = enable_rise;
	assign IRQ_O = |(irq_stat_reg & irq_mask_reg);

	always @* begin
		wr_ok = 1'b1;
		case (wa)
		`OFF_CTRL, `OFF_IRQ_STAT, `OFF_IRQ_MASK: wr_ok = 1'b1;
		`OFF_GAIN: wr_ok = (wd16 >= `GAIN_MIN) && (wd16 <= `GAIN_MAX);
		`OFF_OFFSET: wr_ok = (wd16 >= `OFFSET_MIN) && (wd16 <= `OFFSET_MAX);
		`OFF_UPPER, `OFF_LOWER: wr_ok = ({1'b0, wd[15:0]} <= `MARGIN_MAX);
		default: wr_ok = 1'b0;
		endcase
	end

	always @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 32'h00000000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O <= `OKAY;
			ctrl_reg <= 32'h00000000;
			gain_reg <= 16'sd100;
			offset_reg <= 16'sd0;
			upper_margin_reg <= 16'h0000;
			lower_margin_reg <= 16'h0000;
			irq_mask_reg <= 3'h0;
			irq_stat_reg <= 3'h0;
		end else begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
				w_held_reg <= 1'b1;
				wdata_reg <= S_AXI_WDATA_I;
				wstrb_reg <= S_AXI_WSTRB_I;
			end
			if (S_AXI_BVALID_O && S_AXI_BREADY_I)
				S_AXI_BVALID_O <= 1'b0;
			// Partial strobes are refused: fields span lanes and a split write would tear them
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O <= wr_accept ? `OKAY : `SLVERR;
			end
			// Set wins over a same-cycle write-one clear
			irq_stat_reg <= irq_stat_reg | irq_events;
			if (wr_accept) begin
				case (wa)
				`OFF_CTRL: ctrl_reg <= wd & 32'h00ffff3f;
				`OFF_GAIN: gain_reg <= wd16;
				`OFF_OFFSET: offset_reg <= wd16;
				`OFF_UPPER: upper_margin_reg <= wd[15:0];
				`OFF_LOWER: lower_margin_reg <= wd[15:0];
				`OFF_IRQ_MASK: irq_mask_reg <= wd[2:0];
				`OFF_IRQ_STAT: irq_stat_reg <= (irq_stat_reg & ~wd[2:0]) | irq_events;
				default: ctrl_reg <= ctrl_reg;
				endcase
			end
		end
	end

	always @* begin
		rd_ok = 1'b1;
		case (S_AXI_ARADDR_I[7:0])
		`OFF_CTRL: rd_mux = ctrl_reg;
		`OFF_GAIN: rd_mux = {{16{gain_reg[15]}}, gain_reg};
		`OFF_OFFSET: rd_mux = {{16{offset_reg[15]}}, offset_reg};
		`OFF_UPPER: rd_mux = {16'h0000, upper_margin_reg};
		`OFF_LOWER: rd_mux = {16'h0000, lower_margin_reg};
		`OFF_STATUS: rd_mux = status_word;
		`OFF_IRQ_STAT: rd_mux = {29'h0, irq_stat_reg};
		`OFF_IRQ_MASK: rd_mux = {29'h0, irq_mask_reg};
		`OFF_REF: rd_mux = reference_reg;
		`OFF_LIVE: rd_mux = scaled_live;
		`OFF_OUT: rd_mux = {{16{SCALED_OUT_O[15]}}, SCALED_OUT_O};
		default: begin
			rd_mux = 32'h00000000;
			rd_ok = 1'b0;
		end
		endcase
	end

	always @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O <= 32'h00000000;
			S_AXI_RRESP_O <= `OKAY;
		end else begin
			// Data is captured at the address handshake, so a live value cannot tear while it waits
			if (S_AXI_RVALID_O && S_AXI_RREADY_I)
				S_AXI_RVALID_O <= 1'b0;
			if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
				S_AXI_RVALID_O <= 1'b1;
				S_AXI_RDATA_O <= rd_mux;
				S_AXI_RRESP_O <= rd_ok ? `OKAY : `SLVERR;
			end
		end
	end
endmodule

/* sim/analog_src.sv */
`timescale 1ns/100ps
module analog_src (
	input wire clk_i,
	input wire signed [15:0] level_i,
	input wire signed [15:0] blk_i,
	input wire signed [15:0] amp_i,
	output reg signed [15:0] analog_o = 16'sh0000,
	output reg [2047:0] blocks_o = {128{16'h1111}},
	output wire [9:0] phys_o
);
	// Only block 5 is live; the rest carry a pattern so a wrong select shows
	always @(posedge clk_i) begin
		analog_o <= level_i;
		blocks_o[80 +: 16] <= blk_i;
	end
	// Consumer folds the amplifier result into the physical 0..1000 span
	assign phys_o = amp_i < 0 ? 10'd0 : (amp_i > 16'sd1000 ? 10'd1000 : amp_i[9:0]);
endmodule

/* sim/asw_chk.sv */
`timescale 1ns/100ps
module asw_chk (
	input wire CLK_SYS_I,
	input wire RESET_N_I,
	input wire POWER_LOSS_I,
	input wire ENABLE_I,
	input wire TRIP_O,
	input wire signed [15:0] SCALED_OUT_O,
	input wire S_AXI_AWVALID_I,
	input wire S_AXI_AWREADY_O,
	input wire S_AXI_WVALID_I,
	input wire S_AXI_WREADY_O,
	input wire [1:0] S_AXI_BRESP_O,
	input wire S_AXI_BVALID_O,
	input wire S_AXI_BREADY_I,
	input wire S_AXI_ARVALID_I,
	input wire S_AXI_ARREADY_O,
	input wire [31:0] S_AXI_RDATA_O,
	input wire S_AXI_RVALID_O,
	input wire S_AXI_RREADY_I
);
	default clocking @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!RESET_N_I);
	chk_trip_en_off: assert property (!ENABLE_I |=> !TRIP_O) else $error("trip high with enable low");
	chk_trip_rise: assert property ($rose(ENABLE_I) |=> !TRIP_O) else $error("trip high in rise cycle");
	chk_trip_ploss: assert property (POWER_LOSS_I |=> !TRIP_O) else $error("trip high at power loss");
	chk_out_range: assert property (SCALED_OUT_O >= -16'sd32767) else $error("amplifier output wrapped");
	chk_b_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
		else $error("write response dropped");
	chk_r_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
		else $error("read data dropped");
	chk_r_lat: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O) else $error("read late");
	chk_b_lat: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
		|=> ##1 S_AXI_BVALID_O) else $error("write response late");
endmodule
bind analog_scaler_watchdog asw_chk chk (.*);

/* sim/tb_top.sv */
`timescale 1ns/100ps
`include "scaler_wd_defines.vh"
module tb_top;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg pl = 1'b0;
	reg en = 1'b0;
	reg signed [15:0] lvl = 16'sh0000;
	reg signed [15:0] blk = 16'sh0000;
	reg [3:0] strb = 4'hf;
	reg [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0;
	reg awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	wire awr, wrd, bv, arr, rv, trip, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire signed [15:0] ain, sout;
	wire [2047:0] blocks;
	wire [9:0] phys;
	integer fail_count = 0;
	integer total_checks = 0;
	initial forever #20 clk = ~clk;
	analog_src src (.clk_i(clk), .level_i(lvl), .blk_i(blk), .amp_i(sout), .analog_o(ain), .blocks_o(blocks),
		.phys_o(phys));
	analog_scaler_watchdog dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .POWER_LOSS_I(pl), .ENABLE_I(en),
		.ANALOG_IN_I(ain), .BLOCK_VALUES_I(blocks), .TRIP_O(trip), .SCALED_OUT_O(sout), .IRQ_O(irq),
		.S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
		.S_AXI_WSTRB_I(strb), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(bresp),
		.S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
		.S_AXI_RREADY_I(rr));
	task summarize;
		begin
			$display("checks %0d mismatches %0d", total_checks, fail_count);
			if (fail_count == 0 && total_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task hang(input done);
		begin
			if (!done) begin
				fail_count = fail_count + 1;
				summarize;
			end
		end
	endtask
	task wr(input [31:0] a, input [31:0] d, input [1:0] r);
		integer n;
		reg ta, tw, bt;
		reg [1:0] rb;
		begin
			@(posedge clk);
			awa <= a;
			wd <= d;
			awv <= 1'b1;
			wv <= 1'b1;
			br <= 1'b1;
			bt = 1'b0;
			for (n = 0; n < 50 && !bt; n = n + 1) begin
				@(negedge clk);
				ta = awv && awr;
				tw = wv && wrd;
				bt = bv;
				rb = bresp;
				@(posedge clk);
				if (ta)
					awv <= 1'b0;
				if (tw)
					wv <= 1'b0;
			end
			br <= 1'b0;
			@(negedge clk);
			hang(bt);
			chk({30'h0, rb}, {30'h0, r});
		end
	endtask
	task rd(input [31:0] a, input [31:0] d, input [1:0] r);
		integer n;
		reg ta, rt;
		reg [33:0] got;
		begin
			@(posedge clk);
			ara <= a;
			arv <= 1'b1;
			rr <= 1'b1;
			rt = 1'b0;
			for (n = 0; n < 50 && !rt; n = n + 1) begin
				@(negedge clk);
				ta = arv && arr;
				rt = rv;
				got = {rresp, rdata};
				@(posedge clk);
				if (ta)
					arv <= 1'b0;
			end
			rr <= 1'b0;
			@(negedge clk);
			hang(rt);
			chk(got[31:0], d);
			chk({30'h0, got[33:32]}, {30'h0, r});
		end
	endtask
	// Source adds one cycle, trip and output one more; four covers both
	// Tasks start on a rising edge and end mid-cycle, so outputs are read settled
	task lv(input [15:0] v, input t);
		begin
			@(posedge clk);
			lvl <= v;
			repeat (4) @(posedge clk);
			@(negedge clk);
			chk({31'h0, trip}, {31'h0, t});
		end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`OFF_GAIN, 32'h64, `OKAY);
		rd(`OFF_CTRL, 32'h0, `OKAY);
		wr(`OFF_GAIN, 32'h3e9, `SLVERR);
		wr(`OFF_GAIN, 32'hfffffc17, `SLVERR);
		wr(`OFF_OFFSET, 32'h2711, `SLVERR);
		wr(`OFF_UPPER, 32'h4e21, `SLVERR);
		wr(`OFF_LOWER, 32'h4e20, `OKAY);
		@(posedge clk) strb <= 4'h3;
		wr(`OFF_GAIN, 32'h64, `SLVERR);
		@(posedge clk) strb <= 4'hf;
		wr(32'h40, 32'h0, `SLVERR);
		rd(32'h40, 32'h0, `SLVERR);
		wr(`OFF_REF, 32'h0, `SLVERR);
		wr(`OFF_UPPER, 32'ha, `OKAY);
		wr(`OFF_LOWER, 32'h5, `OKAY);
		wr(`OFF_CTRL, 32'h30, `OKAY);
		wr(`OFF_IRQ_MASK, 32'h1, `OKAY);
		lv(100, 1'b0);
		@(posedge clk) en <= 1'b1;
		lv(100, 1'b0);
		rd(`OFF_REF, 32'h64, `OKAY);
		lv(110, 1'b0);
		lv(111, 1'b1);
		lv(95, 1'b0);
		lv(94, 1'b1);
		chk({31'h0, irq}, 32'h1);
		wr(`OFF_IRQ_MASK, 32'h0, `OKAY);
		chk({31'h0, irq}, 32'h0);
		wr(`OFF_IRQ_MASK, 32'h1, `OKAY);
		lv(100, 1'b0);
		chk({31'h0, irq}, 32'h1);
		wr(`OFF_IRQ_STAT, 32'h1, `OKAY);
		chk({31'h0, irq}, 32'h0);
		rd(`OFF_IRQ_STAT, 32'h6, `OKAY);
		@(posedge clk) blk <= 16'sd20;
		wr(`OFF_CTRL, 32'h0536, `OKAY);
		lv(115, 1'b0);
		lv(121, 1'b1);
		@(posedge clk) pl <= 1'b1;
		lv(121, 1'b0);
		rd(`OFF_STATUS, 32'h6, `OKAY);
		@(posedge clk) pl <= 1'b0;
		lv(121, 1'b1);
		@(posedge clk) en <= 1'b0;
		lv(121, 1'b0);
		wr(`OFF_GAIN, 32'hfa, `OKAY);
		wr(`OFF_OFFSET, 32'hffffff9c, `OKAY);
		lv(41, 1'b0);
		rd(`OFF_LIVE, 32'h2, `OKAY);
		lv(-41, 1'b0);
		rd(`OFF_LIVE, 32'hffffff36, `OKAY);
		wr(`OFF_CTRL, 32'h1, `OKAY);
		wr(`OFF_GAIN, 32'h3e8, `OKAY);
		wr(`OFF_OFFSET, 32'h2710, `OKAY);
		lv(5000, 1'b0);
		chk({16'h0, sout}, 32'h7fff);
		lv(-5000, 1'b0);
		chk({16'h0, sout}, 32'h8001);
		lv(-900, 1'b0);
		chk({16'h0, sout}, 32'h3e8);
		chk({22'h0, phys}, 32'h3e8);
		summarize;
	end
endmodule
